/* rtl/axh_regs.svh */
// Constants for the stream handshake channel
//
// How it works
// - Beat moves only when valid and ready high
// - Ready may rise before, with or after valid
// - Ready is registered, never from valid directly
// - Ready pre-asserted while buffer has room
// - No combinational paths between the channels
// - Reverse information only on side signals
// - Missing ready means ready always high
// - Payload counts only on a completed handshake
// - Only valid is mandatory on a channel
// - Ports named role, axis, bus, signal
// - Sub-channels broken out as byte-aligned wiring
`ifndef AXH_REGS_SVH
`define AXH_REGS_SVH

// ----------------------------------------------------------------
// Widths and field positions
// ----------------------------------------------------------------
`define AXH_DATA_W 32
`define AXH_USER_W 8
`define AXH_LANE_W 16
`define AXH_RE_LSB 0
`define AXH_IM_LSB 16
`define AXH_CNT_W 16

// ----------------------------------------------------------------
// Buffer depth and reset values
// ----------------------------------------------------------------
`define AXH_BUF_DEPTH 2
`define AXH_CNT_RST 16'h0000
`define AXH_DATA_RST 32'h0000_0000

`endif

/* rtl/axh_pkg.sv */
// Types shared by the stream handshake channel modules
`include "axh_regs.svh"

package axh_pkg;

    // ------------------------------------------------------------
    // Beat carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic [`AXH_DATA_W-1:0] tdata;
        logic [`AXH_USER_W-1:0] tuser;
        logic tlast;
    } axh_beat_t;

    // ------------------------------------------------------------
    // Watch on the incoming source, Gray along idle-held-idle
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        AXH_IDLE = 1'b0,
        AXH_HELD = 1'b1
    } axh_watch_t;

    // ------------------------------------------------------------
    // Buffer state
    // ------------------------------------------------------------
    typedef struct packed {
        axh_beat_t [`AXH_BUF_DEPTH-1:0] slot;
        logic [1:0] count;
        logic inReady;
        logic outValid;
    } axh_buf_t;

    // ------------------------------------------------------------
    // Channel state
    // ------------------------------------------------------------
    typedef struct packed {
        axh_watch_t watch;
        axh_beat_t heldBeat;
        logic withdrawErr;
        logic changeErr;
        logic monValid;
        logic [`AXH_DATA_W-1:0] monData;
        logic [`AXH_CNT_W-1:0] beatCount;
        logic [`AXH_CNT_W-1:0] packetCount;
        logic [`AXH_CNT_W-1:0] curLen;
        logic [`AXH_CNT_W-1:0] lastLen;
        logic [`AXH_CNT_W-1:0] stallCount;
    } axh_chan_t;

endpackage : axh_pkg

/* rtl/axh_skid_buf.sv */
// Two-entry shift buffer with registered valid and ready
`timescale 1ns/1ps

module axh_skid_buf
    import axh_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Filling side
    input wire logic inValid,
    output logic inReady,
    input wire axh_beat_t inBeat,
    // Draining side
    output logic outValid,
    input wire logic outReady,
    output axh_beat_t outBeat
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    axh_buf_t st;
    axh_buf_t next_st;
    logic push;
    logic pop;
    logic [1:0] wrIdx;

    // Handshakes on both sides
    assign push = inValid && st.inReady;
    assign pop = st.outValid && outReady;

    // Next state; head always sits in slot 0 so outputs are flops
    always_comb begin
        next_st = st;
        wrIdx = st.count - {1'b0, pop};
        if (pop) begin
            for (int i = 0; i < `AXH_BUF_DEPTH - 1; i++) begin
                next_st.slot[i] = st.slot[i + 1];
            end
        end
        if (push) begin
            next_st.slot[wrIdx[0]] = inBeat;
        end
        next_st.count = st.count + {1'b0, push} - {1'b0, pop};
        // Ready comes from fill level only, never from inValid
        next_st.inReady = (next_st.count != 2'(`AXH_BUF_DEPTH));
        next_st.outValid = (next_st.count != 2'd0);
    end

    // Register; ready is up from reset so it waits ahead of data
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
            st.inReady <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flops
    assign inReady = st.inReady;
    assign outValid = st.outValid;
    assign outBeat = st.slot[0];

endmodule : axh_skid_buf

/* rtl/axh_channel.sv */
// Stream channel: buffered pass-through with monitor and watchdog
`timescale 1ns/1ps
`include "axh_regs.svh"

module axh_channel
    import axh_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Incoming stream from the source
    input wire logic s_axis_cplx_tvalid,
    output logic s_axis_cplx_tready,
    input wire logic [`AXH_DATA_W-1:0] s_axis_cplx_tdata,
    input wire logic [`AXH_USER_W-1:0] s_axis_cplx_tuser,
    input wire logic s_axis_cplx_tlast,
    // Outgoing stream to the destination
    output logic m_axis_cplx_tvalid,
    input wire logic m_axis_cplx_tready,
    output logic [`AXH_DATA_W-1:0] m_axis_cplx_tdata,
    output logic [`AXH_USER_W-1:0] m_axis_cplx_tuser,
    output logic m_axis_cplx_tlast,
    // Broken-out sub-channels of the outgoing data
    output logic [`AXH_LANE_W-1:0] m_axis_cplx_re_tdata,
    output logic [`AXH_LANE_W-1:0] m_axis_cplx_im_tdata,
    // Forward-only monitor channel, no ready
    output logic m_axis_mon_tvalid,
    output logic [`AXH_DATA_W-1:0] m_axis_mon_tdata,
    // Out-of-band status and control
    input wire logic errClear,
    output logic withdrawErr,
    output logic changeErr,
    output logic [`AXH_CNT_W-1:0] beatCount,
    output logic [`AXH_CNT_W-1:0] packetCount,
    output logic [`AXH_CNT_W-1:0] lastLen,
    output logic [`AXH_CNT_W-1:0] stallCount
);

    // ------------------------------------------------------------
    // Buffer in the data path
    // ------------------------------------------------------------
    axh_beat_t inBeat;
    axh_beat_t outBeat;
    logic bufInReady;
    logic bufOutValid;

    // Pack the incoming payload
    assign inBeat.tdata = s_axis_cplx_tdata;
    assign inBeat.tuser = s_axis_cplx_tuser;
    assign inBeat.tlast = s_axis_cplx_tlast;

    // A stall downstream fills this and drops ready upstream
    axh_skid_buf uBuf (
        .mclk(mclk),
        .reset_n(reset_n),
        .inValid(s_axis_cplx_tvalid),
        .inReady(bufInReady),
        .inBeat(inBeat),
        .outValid(bufOutValid),
        .outReady(m_axis_cplx_tready),
        .outBeat(outBeat)
    );

    // ------------------------------------------------------------
    // Channel state
    // ------------------------------------------------------------
    axh_chan_t st;
    axh_chan_t next_st;
    logic inFire;
    logic outFire;
    logic setWithdraw;
    logic setChange;

    // Transfers on each side
    assign inFire = s_axis_cplx_tvalid && bufInReady;
    assign outFire = bufOutValid && m_axis_cplx_tready;

    // Next state of watchdog, monitor and counters
    always_comb begin
        next_st = st;
        setWithdraw = 1'b0;
        setChange = 1'b0;

        // Watch a pending beat; only flags, the beat is not altered
        unique case (st.watch)
            AXH_IDLE: begin
                if (s_axis_cplx_tvalid && !bufInReady) begin
                    next_st.watch = AXH_HELD;
                    next_st.heldBeat = inBeat;
                end
            end
            AXH_HELD: begin
                if (!s_axis_cplx_tvalid) begin
                    setWithdraw = 1'b1;
                    next_st.watch = AXH_IDLE;
                end else begin
                    if (inBeat != st.heldBeat) begin
                        setChange = 1'b1;
                    end
                    next_st.heldBeat = inBeat;
                    if (bufInReady) begin
                        next_st.watch = AXH_IDLE;
                    end
                end
            end
        endcase

        // Sticky flags; a new event wins over a clear
        next_st.withdrawErr = (st.withdrawErr && !errClear)
            || setWithdraw;
        next_st.changeErr = (st.changeErr && !errClear)
            || setChange;

        // Monitor copy comes from flops, one cycle after the beat
        next_st.monValid = inFire;
        if (inFire) begin
            next_st.monData = s_axis_cplx_tdata;
        end

        // Counts advance only on a taken beat
        if (inFire) begin
            next_st.beatCount = st.beatCount + 16'h0001;
            if (s_axis_cplx_tlast) begin
                next_st.packetCount = st.packetCount + 16'h0001;
                next_st.lastLen = st.curLen + 16'h0001;
                next_st.curLen = `AXH_CNT_RST;
            end else begin
                next_st.curLen = st.curLen + 16'h0001;
            end
        end

        // Back-pressure cycles seen downstream; wraps at full scale
        if (bufOutValid && !m_axis_cplx_tready) begin
            next_st.stallCount = st.stallCount + 16'h0001;
        end
    end

    // Register; the source keeps valid low here, so no beat pends
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
            st.watch <= AXH_IDLE;
            st.monData <= `AXH_DATA_RST;
            st.beatCount <= `AXH_CNT_RST;
            st.packetCount <= `AXH_CNT_RST;
            st.curLen <= `AXH_CNT_RST;
            st.lastLen <= `AXH_CNT_RST;
            st.stallCount <= `AXH_CNT_RST;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outgoing stream, straight from buffer flops
    // ------------------------------------------------------------
    assign s_axis_cplx_tready = bufInReady;
    assign m_axis_cplx_tvalid = bufOutValid;
    assign m_axis_cplx_tdata = outBeat.tdata;
    assign m_axis_cplx_tuser = outBeat.tuser;
    assign m_axis_cplx_tlast = outBeat.tlast;

    // Lanes are plain slices of the head slot, no added logic
    assign m_axis_cplx_re_tdata =
        outBeat.tdata[`AXH_RE_LSB +: `AXH_LANE_W];
    assign m_axis_cplx_im_tdata =
        outBeat.tdata[`AXH_IM_LSB +: `AXH_LANE_W];

    // Monitor lacks ready and last; its receiver must always take
    assign m_axis_mon_tvalid = st.monValid;
    assign m_axis_mon_tdata = st.monData;

    // Status, kept off the ready wire
    assign withdrawErr = st.withdrawErr;
    assign changeErr = st.changeErr;
    assign beatCount = st.beatCount;
    assign packetCount = st.packetCount;
    assign lastLen = st.lastLen;
    assign stallCount = st.stallCount;

endmodule : axh_channel

/* dv/axh_channel_asserts.sv */
// Port-level checks on the stream channel
`timescale 1ns/1ps
`include "axh_regs.svh"

module axh_channel_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Streams
    input wire logic s_axis_cplx_tvalid,
    input wire logic s_axis_cplx_tready,
    input wire logic [`AXH_DATA_W-1:0] s_axis_cplx_tdata,
    input wire logic m_axis_cplx_tvalid,
    input wire logic m_axis_cplx_tready,
    input wire logic [`AXH_DATA_W-1:0] m_axis_cplx_tdata,
    input wire logic [`AXH_LANE_W-1:0] m_axis_cplx_re_tdata,
    input wire logic [`AXH_LANE_W-1:0] m_axis_cplx_im_tdata,
    input wire logic m_axis_mon_tvalid,
    input wire logic [`AXH_DATA_W-1:0] m_axis_mon_tdata,
    // Status
    input wire logic withdrawErr,
    input wire logic [`AXH_CNT_W-1:0] beatCount,
    input wire logic [`AXH_CNT_W-1:0] stallCount
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // Each taken beat shows once on the monitor, with its data
    a_mon_pulse: assert property (
        s_axis_cplx_tvalid && s_axis_cplx_tready |=> m_axis_mon_tvalid)
        else $error("no monitor pulse after a taken beat");
    a_mon_data: assert property (
        s_axis_cplx_tvalid && s_axis_cplx_tready
        |=> m_axis_mon_tdata == $past(s_axis_cplx_tdata))
        else $error("monitor data differs from taken beat");
    a_no_take: assert property (
        !(s_axis_cplx_tvalid && s_axis_cplx_tready) |=> !m_axis_mon_tvalid)
        else $error("monitor pulse without a handshake");
    a_beat_count: assert property (
        s_axis_cplx_tvalid && s_axis_cplx_tready
        |=> beatCount == $past(beatCount) + 16'h0001)
        else $error("beat count did not step");
    // Outgoing beat is sticky and steady while stalled
    a_out_hold: assert property (
        m_axis_cplx_tvalid && !m_axis_cplx_tready
        |=> m_axis_cplx_tvalid && $stable(m_axis_cplx_tdata))
        else $error("outgoing beat changed while stalled");
    a_stall_count: assert property (
        m_axis_cplx_tvalid && !m_axis_cplx_tready
        |=> stallCount == $past(stallCount) + 16'h0001)
        else $error("stall count did not step");
    // Empty buffer keeps ready raised ahead of data
    a_empty_ready: assert property (
        !m_axis_cplx_tvalid |-> s_axis_cplx_tready)
        else $error("ready low with an empty buffer");
    // Sub-channels are plain wiring of the word
    a_lane_split: assert property (
        m_axis_cplx_re_tdata == m_axis_cplx_tdata[15:0]
        && m_axis_cplx_im_tdata == m_axis_cplx_tdata[31:16])
        else $error("sub-channel fields do not match the word");
    a_withdraw_flag: assert property (
        (s_axis_cplx_tvalid && !s_axis_cplx_tready) ##1 !s_axis_cplx_tvalid
        |=> withdrawErr)
        else $error("withdrawn beat not flagged");
endmodule : axh_channel_checker

bind axh_channel axh_channel_checker u_chk (.*);

/* dv/axh_sink.sv */
// Downstream partner: takes beats, stalls on request
`timescale 1ns/1ps

module axh_sink (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Stream back-pressure
    output logic tready,
    // Stall request from the bench
    input wire logic holdOff
);
    // Registered ready, so it may lead or trail valid; carries no news
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tready <= 1'b0;
        end else begin
            tready <= !holdOff;
        end
    end
endmodule : axh_sink

/* dv/testbench.sv */
// Self-checking bench for the stream channel
`timescale 1ns/1ps
`include "axh_regs.svh"

module testbench;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic sValid = 1'b0;
    logic sLast = 1'b0;
    logic errClear = 1'b0;
    logic holdOff = 1'b0;
    logic [`AXH_DATA_W-1:0] sData = 32'h0000_0000;
    logic sReady, mValid, mReady, mLast, monValid, wErr, cErr;
    logic [`AXH_DATA_W-1:0] mData, monData;
    logic [`AXH_USER_W-1:0] mUser;
    logic [`AXH_LANE_W-1:0] reData, imData;
    logic [`AXH_CNT_W-1:0] beats, pkts, lastLen, stalls;
    logic [`AXH_DATA_W-1:0] got[$];
    int fails = 0;
    int n_compared = 0;

    always #5 mclk = ~mclk;

    axh_channel u_dut (.mclk(mclk), .reset_n(reset_n),
        .s_axis_cplx_tvalid(sValid), .s_axis_cplx_tready(sReady),
        .s_axis_cplx_tdata(sData), .s_axis_cplx_tuser(8'h00),
        .s_axis_cplx_tlast(sLast), .m_axis_cplx_tvalid(mValid),
        .m_axis_cplx_tready(mReady), .m_axis_cplx_tdata(mData),
        .m_axis_cplx_tuser(mUser), .m_axis_cplx_tlast(mLast),
        .m_axis_cplx_re_tdata(reData), .m_axis_cplx_im_tdata(imData),
        .m_axis_mon_tvalid(monValid), .m_axis_mon_tdata(monData),
        .errClear(errClear), .withdrawErr(wErr), .changeErr(cErr),
        .beatCount(beats), .packetCount(pkts), .lastLen(lastLen),
        .stallCount(stalls));
    axh_sink u_sink (.mclk(mclk), .reset_n(reset_n), .tready(mReady),
        .holdOff(holdOff));

    // Collect every beat the sink takes
    always @(posedge mclk) begin
        if (mValid === 1'b1 && mReady === 1'b1) got.push_back(mData);
    end

    task results;
        $display("fails=%0d compared=%0d", fails, n_compared);
        if (fails == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    // Holds the beat until ready is seen high at an edge
    // Ready is judged before the edge, where it is settled
    task send(input logic [31:0] d, input logic l);
        int i;
        logic taken;
        sValid = 1'b1;
        sData = d;
        sLast = l;
        i = 0;
        taken = 1'b0;
        do begin
            taken = (sReady === 1'b1);
            @(posedge mclk);
            #1;
            i++;
        end while (!taken && i < 40);
        if (!taken) begin fails++; results(); end
    endtask : send

    task expect_out(input logic [31:0] d);
        int i;
        i = 0;
        while (got.size() == 0 && i < 40) begin tick(1); i++; end
        if (got.size() == 0) begin fails++; results(); end
        check(got.pop_front(), d);
    endtask : expect_out

    task t_reset;
        check(sReady, 1'b1);
        check(mValid, 1'b0);
    endtask : t_reset

    // Back-to-back packet of four beats
    task t_stream;
        for (int k = 0; k < 4; k++) send(32'hA5A5_0000 + k, k == 3);
        sValid = 1'b0;
        for (int k = 0; k < 4; k++) expect_out(32'hA5A5_0000 + k);
        check(beats, 16'h0004);
        check(pkts, 16'h0001);
        check(lastLen, 16'h0004);
        check(monData, 32'hA5A5_0003);
    endtask : t_stream

    // Fill while stalled, then valid leads ready
    task t_stall;
        holdOff = 1'b1;
        tick(2);
        send(32'h1111_0000, 1'b0);
        send(32'h2222_0000, 1'b0);
        tick(1);
        check(sReady, 1'b0);
        holdOff = 1'b0;
        send(32'h3333_0000, 1'b1);
        sValid = 1'b0;
        expect_out(32'h1111_0000);
        expect_out(32'h2222_0000);
        expect_out(32'h3333_0000);
    endtask : t_stall

    // Drop a pending beat, then clear the flag
    task t_withdraw;
        logic [15:0] s0;
        holdOff = 1'b1;
        tick(2);
        send(32'h4444_0000, 1'b0);
        send(32'h5555_0000, 1'b0);
        sData = 32'h6666_0000;
        s0 = stalls;
        tick(3);
        check(stalls, s0 + 16'h0003);
        sValid = 1'b0;
        tick(2);
        check(wErr, 1'b1);
        errClear = 1'b1;
        tick(1);
        errClear = 1'b0;
        tick(1);
        check(wErr, 1'b0);
    endtask : t_withdraw

    // Alter a pending beat, then drain everything
    task t_change;
        sValid = 1'b1;
        sData = 32'h7777_0000;
        tick(2);
        sData = 32'h8888_0000;
        tick(2);
        check(cErr, 1'b1);
        holdOff = 1'b0;
        send(32'h8888_0000, 1'b1);
        sValid = 1'b0;
        expect_out(32'h4444_0000);
        expect_out(32'h5555_0000);
        expect_out(32'h8888_0000);
    endtask : t_change

    initial begin
        repeat (5) @(posedge mclk);
        #1;
        reset_n = 1'b1;
        tick(1);
        t_reset();
        t_stream();
        t_stall();
        t_withdraw();
        t_change();
        tick(3);
        results();
    end
endmodule : testbench
